/* rx_count_desc.sv */
// Purpose: Receive-count descriptor words of eight USB endpoints
// Assumes: AXI4-Lite register access, USB engine on the same clock
// Notes:   Engine reports received byte counts; software sets buffer sizes
`timescale 1ns/1ns
`include "rx_count_map.svh"
module rx_count_desc
    import rx_count_pkg::*;
#(
    parameter int ENDPOINTS = 8
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire rx_report_t  rx_report,
    output logic [9:0]       buffer_size_bytes,
    output logic             size_illegal
);
    // =================================================================
    // Types and storage
    typedef struct packed {
        logic [2:0]  ep_select;
        logic        sel_second;
        logic [15:0] desc_base;
        logic [7:0]  ctrl_dual;
        logic        overflow_seen;
        logic [7:0]  packet_seen;
    } desc_state_t;

    desc_state_t st_q;
    desc_state_t st_d;
    desc_half_t  lo_q   [ENDPOINTS];
    desc_half_t  hi_q   [ENDPOINTS];
    logic [15:0] addr_q [ENDPOINTS];

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;
    desc_half_t  cur_half;
    logic [9:0]  cur_size;
    logic        cur_bad;

    // Endpoint address in processor and local views
    function automatic logic [15:0] proc_addr(input logic [15:0] base, input logic [2:0] n);
        proc_addr = base + 16'({13'h0000, n} * 16'(`PROC_STRIDE)) + 16'(`PROC_RX_COUNT_OFS);
    endfunction

    function automatic logic [15:0] local_addr(input logic [15:0] base, input logic [2:0] n);
        local_addr = base + 16'({13'h0000, n} * 16'(`LOCAL_STRIDE))
                   + 16'(`LOCAL_RX_COUNT_OFS);
    endfunction

    // Merge a software write into a half, keeping the tally
    function automatic desc_half_t sw_merge(input desc_half_t h, input logic [15:0] d,
                                            input logic [1:0] s);
        desc_half_t r;
        r = h;
        if (s[1]) begin
            r.granularity    = d[`GRAN_BIT];
            r.block_quantity = d[`BLKQ_MSB:`BLKQ_LSB];
        end
        if (s[0] && !s[1]) begin
            r.block_quantity[1:0] = d[11:10];
        end
        sw_merge = r;
    endfunction

    // =================================================================
    // Register bus
    rx_axil_slave u_bus (
        .clock   (clock),
        .srst    (srst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // Buffer sizing of the selected half
    assign cur_half = st_q.sel_second ? hi_q[st_q.ep_select] : lo_q[st_q.ep_select];

    rx_size_calc u_size (
        .clock      (clock),
        .srst       (srst),
        .half       (cur_half),
        .size_bytes (cur_size),
        .illegal    (cur_bad)
    );

    // Write decode of control registers
    always_comb begin
        st_d  = st_q;
        wr_ok = 1'b1;
        if (wr_en) begin
            case (wr_addr)
                `OFS_CTRL: begin
                    if (wr_strb[0]) begin
                        st_d.ep_select  = wr_data[2:0];
                        st_d.sel_second = wr_data[3];
                    end
                    if (wr_strb[1]) begin
                        st_d.ctrl_dual = wr_data[15:8];
                    end
                end
                `OFS_DESC_BASE: begin
                    if (wr_strb[0]) begin
                        st_d.desc_base[7:0] = wr_data[7:0];
                    end
                    if (wr_strb[1]) begin
                        st_d.desc_base[15:8] = wr_data[15:8];
                    end
                end
                `OFS_STATUS: begin
                    if (wr_strb[0] && wr_data[0]) begin
                        st_d.overflow_seen = 1'b0;
                    end
                end
                `OFS_EP_SELECT, `OFS_COUNT_WORD, `OFS_DUAL_WORD, `OFS_RX_ADDR: begin
                    wr_ok = 1'b1;
                end
                default: begin
                    wr_ok = 1'b0;
                end
            endcase
        end
        // Engine events win over a same-cycle clear
        if (rx_report.valid) begin
            st_d.packet_seen[rx_report.endpoint] = 1'b1;
            if (rx_report.byte_count > cur_size && cur_half == (rx_report.second_buffer
                    ? hi_q[rx_report.endpoint] : lo_q[rx_report.endpoint])) begin
                st_d.overflow_seen = 1'b1;
            end
        end
    end

    // Descriptor storage: software fields and engine tallies
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < ENDPOINTS; i++) begin
                lo_q[i]   <= 16'(`DESC_RESET);
                hi_q[i]   <= 16'(`DESC_RESET);
                addr_q[i] <= `BASE_RESET;
            end
        end else begin
            if (wr_en && wr_addr == `OFS_COUNT_WORD) begin
                lo_q[st_q.ep_select] <= sw_merge(lo_q[st_q.ep_select], wr_data[15:0],
                                                 wr_strb[1:0]);
            end
            if (wr_en && wr_addr == `OFS_DUAL_WORD) begin
                lo_q[st_q.ep_select] <= sw_merge(lo_q[st_q.ep_select], wr_data[15:0],
                                                 wr_strb[1:0]);
                hi_q[st_q.ep_select] <= sw_merge(hi_q[st_q.ep_select], wr_data[31:16],
                                                 wr_strb[3:2]);
            end
            if (wr_en && wr_addr == `OFS_RX_ADDR) begin
                if (wr_strb[0]) begin
                    addr_q[st_q.ep_select][7:1] <= wr_data[7:1];
                end
                if (wr_strb[1]) begin
                    addr_q[st_q.ep_select][15:8] <= wr_data[15:8];
                end
            end
            if (rx_report.valid) begin
                if (rx_report.second_buffer && st_q.ctrl_dual[rx_report.endpoint]) begin
                    hi_q[rx_report.endpoint].tally <= rx_report.byte_count;
                end else begin
                    lo_q[rx_report.endpoint].tally <= rx_report.byte_count;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (rd_addr)
            `OFS_CTRL:       rd_data = {16'h0000, st_q.ctrl_dual, 4'h0, st_q.sel_second,
                                        st_q.ep_select};
            `OFS_STATUS:     rd_data = {15'h0000, st_q.packet_seen, 8'h00, st_q.overflow_seen};
            `OFS_EP_SELECT:  rd_data = {local_addr(st_q.desc_base, st_q.ep_select),
                                        proc_addr(st_q.desc_base, st_q.ep_select)};
            `OFS_DESC_BASE:  rd_data = {16'h0000, st_q.desc_base};
            `OFS_COUNT_WORD: rd_data = {16'h0000, lo_q[st_q.ep_select]};
            `OFS_DUAL_WORD:  rd_data = {hi_q[st_q.ep_select], lo_q[st_q.ep_select]};
            `OFS_RX_ADDR:    rd_data = {16'h0000, addr_q[st_q.ep_select][15:1], 1'b0};
            `OFS_BUF_SIZE:   rd_data = {21'h00_0000, cur_bad, cur_size};
            default:         rd_ok = 1'b0;
        endcase
    end

    // Sizing outputs straight from the calculator registers
    assign buffer_size_bytes = cur_size;
    assign size_illegal      = cur_bad;

    // =================================================================
    // Checks
    sequence s_report_lo;
        rx_report.valid && !rx_report.second_buffer;
    endsequence

    property p_tally_lands;
        @(posedge clock) disable iff (srst)
        s_report_lo ##1 (st_q.ep_select == $past(rx_report.endpoint))
            |-> lo_q[st_q.ep_select].tally == $past(rx_report.byte_count);
    endproperty
    a_tally_lands: assert property (p_tally_lands) else $error("tally not stored");

    property p_sw_blkq;
        @(posedge clock) disable iff (srst)
        wr_en && wr_addr == `OFS_COUNT_WORD && wr_strb[1]
            |=> lo_q[$past(st_q.ep_select)].block_quantity == $past(wr_data[14:10]);
    endproperty
    a_sw_blkq: assert property (p_sw_blkq) else $error("block quantity not stored");

    property p_gran_bit;
        @(posedge clock) disable iff (srst)
        wr_en && wr_addr == `OFS_COUNT_WORD && wr_strb[1]
            |=> lo_q[$past(st_q.ep_select)].granularity == $past(wr_data[15]);
    endproperty
    a_gran_bit: assert property (p_gran_bit) else $error("granularity not stored");

    property p_sw_keeps_tally;
        @(posedge clock) disable iff (srst)
        wr_en && wr_addr == `OFS_COUNT_WORD && !rx_report.valid
            |=> $stable(lo_q[st_q.ep_select].tally);
    endproperty
    a_sw_keeps_tally: assert property (p_sw_keeps_tally) else $error("tally overwritten");

    property p_dual_hi;
        @(posedge clock) disable iff (srst)
        wr_en && wr_addr == `OFS_DUAL_WORD && wr_strb[3]
            |=> hi_q[$past(st_q.ep_select)].block_quantity == $past(wr_data[30:26]);
    endproperty
    a_dual_hi: assert property (p_dual_hi) else $error("upper half not stored");

    property p_proc_addr;
        @(posedge clock) disable iff (srst)
        1'b1 |-> proc_addr(st_q.desc_base, st_q.ep_select)
            == 16'(st_q.desc_base + 16'({13'h0000, st_q.ep_select} << 4) + 16'h000C);
    endproperty
    a_proc_addr: assert property (p_proc_addr) else $error("endpoint address wrong");

    property p_rx_addr_bit0;
        @(posedge clock) disable iff (srst)
        rd_en && rd_addr == `OFS_RX_ADDR |=> rvalid && !rdata[0];
    endproperty
    a_rx_addr_bit0: assert property (p_rx_addr_bit0) else $error("reserved bit set");

    property p_small_zero_bad;
        @(posedge clock) disable iff (srst)
        !cur_half.granularity && cur_half.block_quantity == 5'h00 ##1 $stable(cur_half)
            |=> size_illegal;
    endproperty
    a_small_zero_bad: assert property (p_small_zero_bad) else $error("zero not flagged");

    property p_large_reserved;
        @(posedge clock) disable iff (srst)
        cur_half.granularity && cur_half.block_quantity[4] |=> size_illegal;
    endproperty
    a_large_reserved: assert property (p_large_reserved) else $error("reserved not flagged");
endmodule

/* rx_count_map.svh */
// Purpose: Offsets, field positions and reset values of the receive-count block
// Assumes: Included by the descriptor block, the size calculator and the bench
// Notes:   Byte addresses on the register bus, 32-bit aligned words
`ifndef RX_COUNT_MAP_SVH
`define RX_COUNT_MAP_SVH

// =====================================================================
// Register bus byte offsets
`define OFS_CTRL            8'h00
`define OFS_STATUS          8'h04
`define OFS_EP_SELECT       8'h08
`define OFS_DESC_BASE       8'h0C
`define OFS_COUNT_WORD      8'h10
`define OFS_DUAL_WORD       8'h14
`define OFS_RX_ADDR         8'h18
`define OFS_BUF_SIZE        8'h1C

// =====================================================================
// Descriptor field positions
`define TALLY_LSB           0
`define TALLY_MSB           9
`define BLKQ_LSB            10
`define BLKQ_MSB            14
`define GRAN_BIT            15
`define HALF_WIDTH          16

// =====================================================================
// Descriptor placement per endpoint
`define PROC_STRIDE         16
`define PROC_RX_COUNT_OFS   12
`define LOCAL_STRIDE        8
`define LOCAL_RX_COUNT_OFS  6

// =====================================================================
// Sizing constants and reset values
`define SMALL_BLOCK_BYTES   2
`define LARGE_BLOCK_BYTES   32
`define LARGE_BLKQ_LIMIT    5'h0F
`define DESC_RESET          32'h0000_0000
`define BASE_RESET          16'h0000

`endif

/* rx_count_pkg.sv */
// Purpose: Types of the receive-count block
// Assumes: rx_count_map.svh holds the numbers
// Notes:   Descriptor half layout shared by the descriptor block and the size calculator
package rx_count_pkg;

    // =================================================================
    // One single-buffer descriptor half
    typedef struct packed {
        logic       granularity;
        logic [4:0] block_quantity;
        logic [9:0] tally;
    } desc_half_t;

    // Packet report from the USB engine
    typedef struct packed {
        logic       valid;
        logic [2:0] endpoint;
        logic       second_buffer;
        logic [9:0] byte_count;
    } rx_report_t;

endpackage

/* rx_size_calc.sv */
// Purpose: Buffer size in bytes from a descriptor half
// Assumes: Same-clock inputs
// Notes:   Registered result, flags illegal settings
`timescale 1ns/1ns
`include "rx_count_map.svh"
module rx_size_calc
    import rx_count_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire desc_half_t half,
    output logic [9:0]      size_bytes,
    output logic            illegal
);
    typedef struct packed {
        logic [9:0] size;
        logic       bad;
    } calc_state_t;

    calc_state_t st_q;
    calc_state_t st_d;

    // Size from granularity and block quantity
    function automatic logic [9:0] buf_size(input desc_half_t h);
        if (h.granularity) begin
            buf_size = 10'(({5'h00, h.block_quantity} + 10'h001) * 10'(`LARGE_BLOCK_BYTES));
        end else begin
            buf_size = 10'({5'h00, h.block_quantity} * 10'(`SMALL_BLOCK_BYTES));
        end
    endfunction

    // Next value
    always_comb begin
        st_d      = st_q;
        st_d.size = buf_size(half);
        st_d.bad  = half.granularity ? (half.block_quantity > `LARGE_BLKQ_LIMIT)
                                     : (half.block_quantity == 5'h00);
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign size_bytes = st_q.size;
    assign illegal    = st_q.bad;

    property p_small_size;
        @(posedge clock) disable iff (srst)
        !half.granularity |=> size_bytes == 10'({5'h00, $past(half.block_quantity)} * 10'h002);
    endproperty
    a_small_size: assert property (p_small_size) else $error("small size wrong");

    property p_large_size;
        @(posedge clock) disable iff (srst)
        half.granularity && half.block_quantity == 5'h0F |=> size_bytes == 10'h200;
    endproperty
    a_large_size: assert property (p_large_size) else $error("large size wrong");

    property p_large_min;
        @(posedge clock) disable iff (srst)
        half.granularity && half.block_quantity == 5'h00 |=> size_bytes == 10'h020 && !illegal;
    endproperty
    a_large_min: assert property (p_large_min) else $error("large minimum wrong");
endmodule

/* rx_axil_slave.sv */
// Purpose: AXI4-Lite slave handshake for a small register file
// Assumes: One outstanding write and one outstanding read
// Notes:   Write address and data accepted in either order
`timescale 1ns/1ns
module rx_axil_slave (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    typedef struct packed {
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bus_state_t;

    bus_state_t st_q;
    bus_state_t st_d;

    // Channel handshakes and register access strobes
    always_comb begin
        st_d    = st_q;
        wr_en   = st_q.aw_have && st_q.w_have && !st_q.bvalid;
        wr_addr = st_q.aw_addr;
        wr_data = st_q.w_data;
        wr_strb = st_q.w_strb;
        rd_en   = arvalid && !st_q.rvalid;
        rd_addr = araddr;
        if (awvalid && !st_q.aw_have) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = awaddr;
        end
        if (wvalid && !st_q.w_have) begin
            st_d.w_have = 1'b1;
            st_d.w_data = wdata;
            st_d.w_strb = wstrb;
        end
        if (wr_en) begin
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = wr_ok ? 2'h0 : 2'h2;
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end
        if (rd_en) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd_ok ? rd_data : 32'h0000_0000;
            st_d.rresp  = rd_ok ? 2'h0 : 2'h2;
        end else if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign awready = !st_q.aw_have;
    assign wready  = !st_q.w_have;
    assign bvalid  = st_q.bvalid;
    assign bresp   = st_q.bresp;
    assign arready = !st_q.rvalid;
    assign rvalid  = st_q.rvalid;
    assign rdata   = st_q.rdata;
    assign rresp   = st_q.rresp;
endmodule

/* rx_engine_model.sv */
// Purpose: USB engine model that reports received OUT or SETUP packets
// Assumes: Same clock as the block
// Notes:   One-cycle report pulse; count is inverted once the pulse is over
`timescale 1ns/1ns
module rx_engine_model
    import rx_count_pkg::*;
(
    input  wire logic clock,
    output rx_report_t rx_report
);
    // =================================================================
    // Idle report
    initial rx_report = '0;

    // One packet report, held for a single cycle
    task automatic send(input logic [2:0] ep, input logic sb, input logic [9:0] c);
        @(posedge clock);
        rx_report <= '{1'b1, ep, sb, c};
        @(posedge clock);
        rx_report <= '{1'b0, ~ep, ~sb, ~c};
    endtask
endmodule

/* usb_rx_buffer_descriptor_count_bench.sv */
// Purpose: Self-checking bench of the receive-count descriptor block
// Assumes: AXI4-Lite master tasks, engine model beside the block
// Notes:   Sizing rows in one loop, awkward cases hand-written after it
`timescale 1ns/1ns
`include "rx_count_map.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module usb_rx_buffer_descriptor_count_bench;
    import rx_count_pkg::*;
    logic        clock, srst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, size_illegal;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [9:0]  buffer_size_bytes;
    rx_report_t  rx_report;
    int          err_count, tests_run;
    logic [5:0]  rows [6] = '{6'h01, 6'h1F, 6'h00, 6'h20, 6'h30, 6'h2F};

    // =================================================================
    // Design, engine model, clock
    rx_count_desc DUT (
        .clock(clock), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_report(rx_report), .buffer_size_bytes(buffer_size_bytes),
        .size_illegal(size_illegal)
    );
    rx_engine_model eng (.clock(clock), .rx_report(rx_report));
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end

    // =================================================================
    // Register bus tasks; readies sampled at the falling edge before use
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tb;
        @(posedge clock);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            rs = bresp;
            @(posedge clock);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end while (!tb);
        bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ta, tb;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(negedge clock);
            ta = arvalid && arready;
            tb = rvalid && rready;
            {rd, rs} = {rdata, rresp};
            @(posedge clock);
            if (ta) arvalid <= 0;
        end while (!tb);
        rready <= 0;
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial begin
        #400000;
        err_count++;
        close_out();
    end

    // =================================================================
    // Main sequence
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (3) @(posedge clock);
        srst <= 0;
        rdr(`OFS_COUNT_WORD);
        `CHK("reset word", 32'h0000_0000, rd)
        $display("done reset");
        // Sizing rows: bit 5 granularity, bits 4:0 block quantity
        foreach (rows[i]) begin
            wr(`OFS_COUNT_WORD, {16'h0000, rows[i][5:0], 10'h000}, 4'h3);
            rdr(`OFS_BUF_SIZE);
            if (rows[i][5]) begin
                `CHK("ill", rows[i][4], rd[10])
                if (!rows[i][4]) `CHK("sz32", 10'(32 * (rows[i][4:0] + 1)), rd[9:0])
            end else begin
                `CHK("ill", rows[i][4:0] == 0, rd[10])
                if (rows[i][4:0] != 0) `CHK("sz2", 10'(2 * rows[i][4:0]), rd[9:0])
            end
            `CHK("port ill", rows[i][5] ? rows[i][4] : (rows[i][4:0] == 5'h00), size_illegal)
        end
        `CHK("port sz", 10'h200, buffer_size_bytes)
        $display("done sizing");
        // Engine count on endpoint 3, software cannot overwrite it
        wr(`OFS_CTRL, 32'h0000_0803, 4'h3);
        eng.send(3'h3, 1'b0, 10'h155);
        wr(`OFS_COUNT_WORD, 32'h0000_0AAA, 4'h3);
        rdr(`OFS_COUNT_WORD);
        `CHK("tally", 32'h0000_0955, rd)
        eng.send(3'h3, 1'b1, 10'h2AA);
        wr(`OFS_DUAL_WORD, 32'h8C00_0000, 4'hC);
        rdr(`OFS_DUAL_WORD);
        `CHK("dual", 32'h8EAA_0955, rd)
        // Packet seen on endpoint 3, overflow against the empty lower half, then cleared
        rdr(`OFS_STATUS);
        `CHK("status", 32'h0000_1001, rd)
        wr(`OFS_STATUS, 32'h0000_0001, 4'h1);
        rdr(`OFS_STATUS);
        `CHK("status clr", 32'h0000_1000, rd)
        wr(`OFS_CTRL, 32'h0000_080B, 4'h3);
        rdr(`OFS_BUF_SIZE);
        `CHK("upper sz", 10'h080, rd[9:0])
        $display("done tally");
        // Descriptor placement and receive address
        wr(`OFS_DESC_BASE, 32'h0000_0100, 4'h3);
        wr(`OFS_CTRL, 32'h0000_0005, 4'h3);
        rdr(`OFS_EP_SELECT);
        `CHK("place", 32'h012E_015C, rd)
        wr(`OFS_RX_ADDR, 32'h0000_FFFF, 4'h3);
        rdr(`OFS_RX_ADDR);
        `CHK("rxaddr", 16'hFFFE, rd[15:0])
        // Unmapped place is refused
        wr(8'h20, 32'hFFFF_FFFF, 4'hF);
        `CHK("bresp", 2'h2, rs)
        rdr(8'h20);
        `CHK("rresp", 2'h2, rs)
        `CHK("rdata", 32'h0000_0000, rd)
        $display("done placement");
        close_out();
    end
endmodule
